/* File: overcurrent_timer.sv */
// Overcurrent duration timer: wake on long excess, short flag on early release
module overcurrent_timer #(
  parameter int CNT_W = 19
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic armed,
  input wire logic over_current,
  input wire logic [CNT_W-1:0] limit,
  output logic long_event,
  output logic short_event
);

  if (CNT_W < 11 || CNT_W > 24) begin
    $error("overcurrent_timer: CNT_W out of range");
  end

  logic [CNT_W-1:0] count;
  logic fired;
  logic prev_over;
  wire active = armed && over_current;
  wire reach = active && !fired && (count == limit - CNT_W'(1));
  wire released = armed && prev_over && !over_current;
  wire [CNT_W-1:0] next_count = active ? ((count == '1) ? count : count + CNT_W'(1)) :
                                CNT_W'(0);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      fired <= 1'b0;
      prev_over <= 1'b0;
      long_event <= 1'b0;
      short_event <= 1'b0;
    end else begin
      count <= next_count;
      fired <= active && (fired || reach);
      prev_over <= active;
      long_event <= reach;
      short_event <= released && !fired;
    end
  end

endmodule

/* File: spi_host_model.sv */
// Host side model driving decoded setup writes and watchdog refresh frames
module spi_host_model (
  input wire logic clk,
  output logic wr_valid,
  output logic [4:0] wr_addr,
  output logic [7:0] wr_data,
  output logic frame_valid,
  output logic frame_16bit,
  output logic code_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_valid = 1'b0;
    wr_addr = 5'h00;
    wr_data = 8'h00;
    frame_valid = 1'b0;
    frame_16bit = 1'b0;
    code_ok = 1'b0;
  end
  // Released wr_data and code_ok show the inverse; wr_addr and frame_16bit keep their last value
  task write_reg(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_valid = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
    wr_valid = 1'b0;
    wr_data = ~d;
  endtask
  task send_frame(input logic w16, input logic ok);
    @(negedge clk);
    frame_valid = 1'b1;
    frame_16bit = w16;
    code_ok = ok;
    @(negedge clk);
    frame_valid = 1'b0;
    code_ok = ~ok;
  endtask
endmodule

/* File: watchdog_setup_config.sv */
// Watchdog setup register, refresh qualification and low-power supply handling
// Functional notes
// - The setup register takes writes only while the device is in setup mode.
// - With the deadline bit set, an interrupt source read must follow within the current plus two whole periods.
// - Without watchdog in low-power supply-on mode, codes 00/01 ignore overcurrent, 10 wakes after 100 us, 11 after the wake time.
// - With watchdog and codes 00/01, overcurrent has no effect and refresh comes only by command.
// - With watchdog and code 10, overcurrent longer than 100 us is a wake-up.
// - With watchdog and code 11, overcurrent shorter than the wake time refreshes, longer wakes.
// - With the fault bit clear, the fault pin goes low with the first reset output low.
// - With the fault bit set, the fault pin goes low only on the second consecutive reset pulse.
// - Scheme 00 accepts a simple refresh in an 8-bit or 16-bit frame.
// - Schemes 01, 10, 11 need the challenge code in one, two or four 16-bit frames.
// - With the gate bit clear the watchdog is a timeout and a refresh is taken at any time.
// - With the gate bit set a refresh is taken only in the second half of the period.
// - With keep-on clear, low battery disables the logic supply and resets; with it set the regulator stays on.
module watchdog_setup_config
  import watchdog_setup_pkg::*;
#(
  parameter int WAKE_W = 19
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic setup_mode,
  input wire logic wr_valid,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] setup_rd_data,
  input wire logic frame_valid,
  input wire logic frame_16bit,
  input wire logic code_ok,
  input wire logic second_half,
  input wire logic period_end,
  input wire logic irq_event,
  input wire logic irq_source_read,
  input wire logic low_power_supply_on_mode,
  input wire logic watchdog_in_lp,
  input wire logic current_over_limit,
  input wire logic [WAKE_W-1:0] overcurrent_wake_time,
  input wire logic reset_out_b,
  input wire logic fault_clear,
  input wire logic battery_supply_low,
  output logic refresh_ok,
  output logic refresh_error,
  output logic irq_deadline_miss,
  output logic oc_wake_event,
  output logic oc_refresh,
  output logic fault_indicator_out_b,
  output logic regulator_enable,
  output logic supply_reset_req
);

  if (WAKE_W < 11 || WAKE_W > 24) begin
    $error("watchdog_setup_config: WAKE_W out of range");
  end
  if ((1 << WAKE_W) <= OC_WAKE_MAX_CYCLES) begin
    $error("watchdog_setup_config: WAKE_W too small");
  end

  // Setup register
  logic [7:0] setup;
  wire setup_wr = wr_valid && setup_mode && (wr_addr == SETUP_ADDR);
  wire irq_read_deadline = setup[IRQ_DEADLINE_BIT];
  wire oc_mode_t supply_overcurrent_sel = oc_mode_t'({setup[OC_SEL_BIT], setup[OC_TIMED_BIT]});
  wire fault_pin_on_second_reset = setup[FAULT_SECOND_BIT];
  wire refresh_scheme_t refresh_scheme =
    refresh_scheme_t'({setup[SCHEME_HI_BIT], setup[SCHEME_LO_BIT]});
  wire period_half_gate_sel = setup[HALF_GATE_BIT];
  wire low_supply_keep_on = setup[KEEP_ON_BIT];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      setup <= SETUP_RESET;
    end else if (setup_wr) begin
      setup <= wr_data;
    end
  end

  assign setup_rd_data = setup;

  // Refresh qualification
  chal_state_t state;
  chal_state_t next_state;
  logic [2:0] chal_count;
  wire is_simple = (refresh_scheme == scheme_simple);
  wire window_ok = !period_half_gate_sel || second_half;
  wire chal_frame_good = frame_valid && frame_16bit && code_ok;
  wire chal_frame_bad = frame_valid && !(frame_16bit && code_ok);
  wire [2:0] next_chal = chal_count + 3'h1;
  wire chal_done = chal_frame_good && (next_chal >= frames_needed(refresh_scheme));
  wire simple_done = frame_valid && is_simple;
  wire cmd_done = simple_done || (!is_simple && chal_done);
  wire cmd_bad = !is_simple && chal_frame_bad;
  wire oc_refresh_ok = oc_refresh && window_ok;
  wire next_ok = (cmd_done && window_ok) || oc_refresh_ok;
  wire next_err = (cmd_done && !window_ok) || cmd_bad;
  wire chal_advance = !is_simple && chal_frame_good && !chal_done;

  always_comb begin
    next_state = state;
    unique case (state)
      chal_idle: if (chal_advance) begin
        next_state = chal_collect;
      end
      chal_collect: if (chal_done || cmd_bad || is_simple) begin
        next_state = chal_idle;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= chal_idle;
      chal_count <= 3'h0;
      refresh_ok <= 1'b0;
      refresh_error <= 1'b0;
    end else begin
      state <= next_state;
      chal_count <= chal_advance ? next_chal : (frame_valid || is_simple) ? 3'h0 : chal_count;
      refresh_ok <= next_ok;
      refresh_error <= next_err;
    end
  end

  // Interrupt source read deadline, counted in period ends
  logic irq_pending;
  logic [1:0] periods_seen;
  wire deadline_hit = irq_pending && period_end && irq_read_deadline &&
                      (periods_seen == 2'(IRQ_EXTRA_PERIODS));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_pending <= 1'b0;
      periods_seen <= 2'h0;
      irq_deadline_miss <= 1'b0;
    end else begin
      if (irq_event && irq_read_deadline) begin
        irq_pending <= 1'b1;
        periods_seen <= 2'h0;
      end else if (irq_source_read || deadline_hit || !irq_read_deadline) begin
        irq_pending <= 1'b0;
        periods_seen <= 2'h0;
      end else if (irq_pending && period_end) begin
        periods_seen <= periods_seen + 2'h1;
      end
      irq_deadline_miss <= deadline_hit && !irq_event;
    end
  end

  // Low-power supply overcurrent handling
  wire oc_armed = low_power_supply_on_mode &&
                  (supply_overcurrent_sel == oc_short_wake || supply_overcurrent_sel == oc_timed);
  wire [WAKE_W-1:0] oc_limit = (supply_overcurrent_sel == oc_timed) ? overcurrent_wake_time :
                               WAKE_W'(SHORT_OC_CYCLES);
  logic oc_long;
  logic oc_short;

  overcurrent_timer #(
    .CNT_W(WAKE_W)
  ) u_oc_timer (
    .clk(clk),
    .rst_b(rst_b),
    .armed(oc_armed),
    .over_current(current_over_limit),
    .limit(oc_limit),
    .long_event(oc_long),
    .short_event(oc_short)
  );

  assign oc_wake_event = oc_long;
  assign oc_refresh = oc_short && watchdog_in_lp && (supply_overcurrent_sel == oc_timed);

  // Fault indicator on first or second consecutive reset pulse
  logic prev_reset_b;
  logic [1:0] reset_count;
  wire reset_fall = prev_reset_b && !reset_out_b;
  wire [1:0] next_reset_count = (reset_count == 2'h2) ? reset_count : reset_count + 2'h1;
  wire fault_now = reset_fall &&
                   (!fault_pin_on_second_reset || reset_count != 2'h0);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_reset_b <= 1'b1;
      reset_count <= 2'h0;
      fault_indicator_out_b <= 1'b1;
    end else begin
      prev_reset_b <= reset_out_b;
      if (reset_fall) begin
        reset_count <= next_reset_count;
      end else if (refresh_ok) begin
        reset_count <= 2'h0;
      end
      if (fault_now) begin
        fault_indicator_out_b <= 1'b0;
      end else if (fault_clear) begin
        fault_indicator_out_b <= 1'b1;
      end
    end
  end

  // Supply-fall handling of the logic regulator
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regulator_enable <= 1'b1;
      supply_reset_req <= 1'b0;
    end else begin
      regulator_enable <= !(battery_supply_low && !low_supply_keep_on);
      supply_reset_req <= battery_supply_low && !low_supply_keep_on;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  write_gate_a: assert property (wr_valid && !setup_mode |=> $stable(setup))
    else $error("setup register changed outside setup mode");
  write_take_a: assert property (setup_wr |=> setup == $past(wr_data))
    else $error("setup register missed a write");
  write_other_a: assert property (
    wr_valid && wr_addr != SETUP_ADDR |=> $stable(setup))
    else $error("setup register changed by another address");

  deadline_miss_a: assert property (irq_deadline_miss |-> $past(irq_read_deadline))
    else $error("deadline miss with deadline disabled");
  deadline_start_a: assert property (
    irq_event && irq_read_deadline |=> irq_pending && periods_seen == 2'h0)
    else $error("interrupt did not start the deadline count");
  deadline_clear_a: assert property (
    irq_source_read && !irq_event |=> !irq_pending)
    else $error("source read did not end the deadline count");
  deadline_cause_a: assert property (
    irq_deadline_miss |-> $past(irq_pending) && $past(period_end))
    else $error("deadline miss without pending interrupt");
  deadline_count_a: assert property (
    irq_pending |-> periods_seen <= 2'(IRQ_EXTRA_PERIODS))
    else $error("deadline count ran past its limit");

  oc_quiet_a: assert property (!oc_armed [*3] |-> !oc_wake_event && !oc_refresh)
    else $error("overcurrent acted while ignored");
  oc_no_wd_a: assert property (
    !watchdog_in_lp |-> !oc_refresh)
    else $error("overcurrent refresh without watchdog");
  oc_wake_cause_a: assert property (
    oc_wake_event |-> $past(oc_armed) && $past(current_over_limit))
    else $error("overcurrent wake without armed excess current");
  oc_refresh_a: assert property (oc_refresh |-> supply_overcurrent_sel == oc_timed)
    else $error("overcurrent refresh outside timed code");
  oc_refresh_take_a: assert property (
    oc_refresh && window_ok |=> refresh_ok)
    else $error("short overcurrent not taken as refresh");

  fault_first_a: assert property (
    reset_fall && !fault_pin_on_second_reset |=> !fault_indicator_out_b)
    else $error("fault pin not low on first reset");
  fault_hold_a: assert property (
    !fault_indicator_out_b && !fault_clear |=> !fault_indicator_out_b)
    else $error("fault pin released without clear");
  fault_clear_a: assert property (
    fault_clear && !fault_now |=> fault_indicator_out_b)
    else $error("fault pin not released by clear");
  fault_second_a: assert property (
    reset_fall && fault_pin_on_second_reset && reset_count == 2'h0
    && fault_indicator_out_b && !fault_clear |=> fault_indicator_out_b)
    else $error("fault pin low on first reset in second-reset mode");
  fault_count_a: assert property (
    reset_fall && fault_pin_on_second_reset && reset_count != 2'h0
    |=> !fault_indicator_out_b)
    else $error("fault pin not low on second reset");

  simple_take_a: assert property (
    frame_valid && is_simple && window_ok && !oc_refresh |=> refresh_ok && !refresh_error)
    else $error("simple refresh not accepted");
  chal_bad_a: assert property (
    frame_valid && !is_simple && !(frame_16bit && code_ok) |=> refresh_error)
    else $error("bad challenge frame not refused");
  chal_partial_a: assert property (
    chal_advance && !oc_refresh |=> !refresh_ok && !refresh_error)
    else $error("partial challenge gave an answer");
  chal_state_a: assert property (
    state == chal_collect |-> chal_count != 3'h0)
    else $error("challenge collection with empty count");
  timeout_any_a: assert property (
    cmd_done && !period_half_gate_sel |=> refresh_ok)
    else $error("refresh refused in timeout mode");
  window_open_a: assert property (
    cmd_done && period_half_gate_sel && second_half |=> refresh_ok)
    else $error("refresh refused in open window");
  window_err_a: assert property (
    cmd_done && period_half_gate_sel && !second_half |=> refresh_error)
    else $error("closed-window refresh not flagged");
  window_shut_a: assert property (
    frame_valid && period_half_gate_sel && !second_half && !oc_refresh |=> !refresh_ok)
    else $error("refresh taken in closed window");

  supply_fall_a: assert property (
    battery_supply_low && !low_supply_keep_on |=> !regulator_enable && supply_reset_req)
    else $error("regulator not disabled on low battery");
  keep_on_a: assert property (
    low_supply_keep_on |=> regulator_enable && !supply_reset_req)
    else $error("regulator dropped with keep-on set");
  supply_ok_a: assert property (
    !battery_supply_low |=> regulator_enable && !supply_reset_req)
    else $error("regulator dropped with battery good");

  chal_four_c: cover property (refresh_scheme == scheme_chal_four && refresh_ok);
  oc_wake_c: cover property (oc_wake_event);
  fault_second_c: cover property (fault_pin_on_second_reset && $fell(fault_indicator_out_b));
  deadline_c: cover property (irq_deadline_miss);
  chal_error_c: cover property (refresh_error && !is_simple);

endmodule

/* File: watchdog_setup_config_tb_top.sv */
// Self-checking bench for the watchdog setup configuration block
module watchdog_setup_config_tb_top;
  import watchdog_setup_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic setup_mode = 1'b0;
  logic second_half = 1'b0;
  logic period_end = 1'b0;
  logic irq_event = 1'b0;
  logic irq_source_read = 1'b0;
  logic lp_mode = 1'b0;
  logic wd_lp = 1'b0;
  logic over = 1'b0;
  logic reset_out_b = 1'b1;
  logic fault_clear = 1'b0;
  logic batt_low = 1'b0;
  logic wr_valid, frame_valid, frame_16bit, code_ok;
  logic [4:0] wr_addr;
  logic [7:0] wr_data, setup_rd_data;
  logic refresh_ok, refresh_error, irq_deadline_miss, oc_wake_event, oc_refresh;
  logic fault_indicator_out_b, regulator_enable, supply_reset_req;
  int error_cnt = 0;
  int checks = 0;
  int n;
  logic got_r, got_ok;

  spi_host_model host_u (.clk(clk), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .frame_valid(frame_valid), .frame_16bit(frame_16bit), .code_ok(code_ok));

  watchdog_setup_config dut_u (.clk(clk), .rst_b(rst_b), .setup_mode(setup_mode),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .setup_rd_data(setup_rd_data),
    .frame_valid(frame_valid), .frame_16bit(frame_16bit), .code_ok(code_ok),
    .second_half(second_half), .period_end(period_end), .irq_event(irq_event),
    .irq_source_read(irq_source_read), .low_power_supply_on_mode(lp_mode),
    .watchdog_in_lp(wd_lp), .current_over_limit(over), .overcurrent_wake_time(19'h00014),
    .reset_out_b(reset_out_b), .fault_clear(fault_clear), .battery_supply_low(batt_low),
    .refresh_ok(refresh_ok), .refresh_error(refresh_error),
    .irq_deadline_miss(irq_deadline_miss), .oc_wake_event(oc_wake_event),
    .oc_refresh(oc_refresh), .fault_indicator_out_b(fault_indicator_out_b),
    .regulator_enable(regulator_enable), .supply_reset_req(supply_reset_req));

  initial begin
    forever #50 clk = ~clk;
  end

  task give_verdict;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input logic c, input string m);
    checks++;
    if (c !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task t_write;
    chk(setup_rd_data === 8'h42 && fault_indicator_out_b === 1'b1, "reset value");
    host_u.write_reg(SETUP_ADDR, 8'h00);
    chk(setup_rd_data === 8'h42, "write outside setup mode");
    setup_mode = 1'b1;
    host_u.write_reg(5'h07, 8'h00);
    chk(setup_rd_data === 8'h42, "write to other address");
    host_u.write_reg(SETUP_ADDR, 8'h00);
    chk(setup_rd_data === 8'h00, "write in setup mode");
  endtask
  task t_refresh;
    host_u.send_frame(1'b0, 1'b0);
    chk(refresh_ok === 1'b1, "simple 8-bit refresh");
    host_u.send_frame(1'b1, 1'b0);
    chk(refresh_ok === 1'b1, "simple 16-bit refresh");
    for (int s = 1; s < 4; s++) begin
      host_u.write_reg(SETUP_ADDR, {4'h0, s[1:0], 2'b00});
      for (int f = 1; f <= (1 << (s - 1)); f++) begin
        host_u.send_frame(1'b1, 1'b1);
        chk(refresh_ok === (f == (1 << (s - 1))), "challenge frame count");
      end
      host_u.send_frame(1'b0, 1'b1);
      chk(refresh_error === 1'b1, "8-bit frame in challenge");
      host_u.send_frame(1'b1, 1'b0);
      chk(refresh_error === 1'b1, "wrong challenge code");
    end
    host_u.write_reg(SETUP_ADDR, 8'h02);
    host_u.send_frame(1'b0, 1'b0);
    chk(refresh_error === 1'b1, "refresh in closed window");
    second_half = 1'b1;
    host_u.send_frame(1'b0, 1'b0);
    chk(refresh_ok === 1'b1, "refresh in open window");
    second_half = 1'b0;
  endtask
  task t_deadline;
    for (int b = 0; b < 3; b++) begin
      host_u.write_reg(SETUP_ADDR, {b != 0, 7'h00});
      irq_event = 1'b1;
      cyc(1);
      irq_event = 1'b0;
      irq_source_read = (b == 2);
      cyc(1);
      irq_source_read = 1'b0;
      for (int p = 0; p < 3; p++) begin
        cyc(3);
        period_end = 1'b1;
        cyc(1);
        period_end = 1'b0;
        chk(irq_deadline_miss === (b == 1 && p == 2), "source read deadline");
      end
    end
  endtask
  task oc_long(input int lim);
    over = 1'b1;
    n = 0;
    while (oc_wake_event !== 1'b1 && n < lim + 10) begin
      cyc(1);
      n++;
    end
    if (n >= lim + 10) begin
      error_cnt++;
      $display("MISMATCH at %0t: no overcurrent wake", $time);
      give_verdict();
    end else begin
      chk(n >= lim - 1 && n <= lim + 2, "overcurrent wake time");
    end
    over = 1'b0;
    cyc(3);
  endtask
  task t_overcurrent;
    lp_mode = 1'b1;
    wd_lp = 1'b1;
    host_u.write_reg(SETUP_ADDR, 8'h60);
    for (int w = 1; w >= 0; w--) begin
      wd_lp = w[0];
      over = 1'b1;
      cyc(5);
      over = 1'b0;
      got_r = 1'b0;
      got_ok = 1'b0;
      repeat (4) begin
        cyc(1);
        got_r = got_r | (oc_refresh === 1'b1);
        got_ok = got_ok | (refresh_ok === 1'b1);
      end
      chk(got_r === w[0] && got_ok === w[0], "short overcurrent refresh");
      oc_long(20);
    end
    wd_lp = 1'b1;
    host_u.write_reg(SETUP_ADDR, 8'h40);
    oc_long(SHORT_OC_CYCLES);
    for (int c = 0; c < 2; c++) begin
      host_u.write_reg(SETUP_ADDR, {2'b00, ~c[0], 5'h00});
      over = 1'b1;
      got_r = 1'b0;
      repeat (40) begin
        cyc(1);
        got_r = got_r | (oc_wake_event === 1'b1) | (oc_refresh === 1'b1);
      end
      over = 1'b0;
      chk(!got_r, "overcurrent ignored");
    end
    lp_mode = 1'b0;
    wd_lp = 1'b0;
  endtask
  task t_fault;
    for (int b = 0; b < 2; b++) begin
      host_u.write_reg(SETUP_ADDR, {3'h0, b[0], 4'h0});
      host_u.send_frame(1'b0, 1'b0);
      fault_clear = 1'b1;
      cyc(1);
      fault_clear = 1'b0;
      for (int k = 0; k < 2; k++) begin
        reset_out_b = 1'b0;
        cyc(3);
        chk(fault_indicator_out_b === (b == 1 && k == 0), "fault pin");
        reset_out_b = 1'b1;
        cyc(3);
      end
    end
  endtask
  task t_supply;
    for (int b = 0; b < 2; b++) begin
      host_u.write_reg(SETUP_ADDR, {7'h00, b[0]});
      batt_low = 1'b1;
      cyc(2);
      chk(regulator_enable === b[0] && supply_reset_req === ~b[0], "supply fall");
      batt_low = 1'b0;
      cyc(2);
    end
  endtask

  initial begin
    cyc(5);
    rst_b = 1'b1;
    t_write();
    t_refresh();
    t_deadline();
    t_overcurrent();
    t_fault();
    t_supply();
    give_verdict();
  end
endmodule

/* File: watchdog_setup_pkg.sv */
// Constants, field layout and types for the watchdog setup configuration block
package watchdog_setup_pkg;

  // Frame address of the setup register (first byte bits 12..8)
  localparam logic [4:0] SETUP_ADDR = 5'h06;

  // Field positions within the setup register
  localparam int IRQ_DEADLINE_BIT = 7;
  localparam int OC_SEL_BIT = 6;
  localparam int OC_TIMED_BIT = 5;
  localparam int FAULT_SECOND_BIT = 4;
  localparam int SCHEME_HI_BIT = 3;
  localparam int SCHEME_LO_BIT = 2;
  localparam int HALF_GATE_BIT = 1;
  localparam int KEEP_ON_BIT = 0;

  // Power-on value: b6 and b1 set, b4 taken as zero
  localparam logic [7:0] SETUP_RESET = 8'h42;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SHORT_OC_TIME_NS = 100000;
  localparam int SHORT_OC_CYCLES = (SHORT_OC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_WAKE_MIN_MS = 3;
  localparam int OC_WAKE_MAX_MS = 32;
  localparam int OC_WAKE_MAX_CYCLES = OC_WAKE_MAX_MS * 1000000 / CLK_PERIOD_NS;

  // Whole periods allowed after the current one for the source read
  localparam int IRQ_EXTRA_PERIODS = 2;

  typedef enum logic [1:0] {
    scheme_simple = 2'h0,
    scheme_chal_one = 2'h1,
    scheme_chal_two = 2'h2,
    scheme_chal_four = 2'h3
  } refresh_scheme_t;

  typedef enum logic [1:0] {
    oc_ignore_a = 2'h0,
    oc_ignore_b = 2'h1,
    oc_short_wake = 2'h2,
    oc_timed = 2'h3
  } oc_mode_t;

  typedef enum logic [1:0] {
    chal_idle = 2'b01,
    chal_collect = 2'b10
  } chal_state_t;

  // Number of 16-bit challenge frames per refresh
  function automatic logic [2:0] frames_needed(input refresh_scheme_t s);
    unique case (s)
      scheme_chal_one: frames_needed = 3'h1;
      scheme_chal_two: frames_needed = 3'h2;
      scheme_chal_four: frames_needed = 3'h4;
      scheme_simple: frames_needed = 3'h1;
    endcase
  endfunction

endpackage
